/* logic/gain_table.sv */
// stiffness level to basic gain lookup with encoder and frame corrections
`timescale 1ns/1ps
`include "servo_autotune_map.svh"
module gain_table
    import servo_autotune_pkg::*;
(
    // lookup
    input wire logic [15:0] level,
    input wire logic abs17,
    input wire logic large_frame,
    output row_t row
);
    logic [4:0] idx;
    row_t raw;

    // out-of-range levels saturate so the table is never overrun
    assign idx = (level > `STIFF_MAX) ? 5'h1f : level[4:0];

    always_comb begin
        unique case (idx)
            5'd0: raw = {16'h14, 16'hf, 16'he74, 16'h5dc, 16'h9b};
            5'd1: raw = {16'h19, 16'h14, 16'haf0, 16'h44c, 16'h73};
            5'd2: raw = {16'h1e, 16'h19, 16'h898, 16'h384, 16'h5e};
            5'd3: raw = {16'h28, 16'h1e, 16'h76c, 16'h320, 16'h54};
            5'd4: raw = {16'h2d, 16'h23, 16'h640, 16'h258, 16'h40};
            5'd5: raw = {16'h37, 16'h2d, 16'h4b0, 16'h1f4, 16'h36};
            5'd6: raw = {16'h4b, 16'h3c, 16'h384, 16'h190, 16'h2c};
            5'd7: raw = {16'h5f, 16'h4b, 16'h2bc, 16'h12c, 16'h22};
            5'd8: raw = {16'h73, 16'h5a, 16'h258, 16'h12c, 16'h22};
            5'd9: raw = {16'h8c, 16'h6e, 16'h1f4, 16'hc8, 16'h18};
            5'd10: raw = {16'haf, 16'h8c, 16'h190, 16'hc8, 16'h17};
            5'd11: raw = {16'h140, 16'hb4, 16'h136, 16'h7e, 16'h10};
            5'd12: raw = {16'h186, 16'hdc, 16'hfa, 16'h67, 16'hd};
            5'd13: raw = {16'h1e0, 16'h10e, 16'hd2, 16'h54, 16'hb};
            5'd14: raw = {16'h276, 16'h15e, 16'ha0, 16'h41, 16'h9};
            5'd15: raw = {16'h2d0, 16'h190, 16'h8c, 16'h39, 16'h8};
            5'd16: raw = {16'h384, 16'h1f4, 16'h78, 16'h2d, 16'h7};
            5'd17: raw = {16'h438, 16'h258, 16'h6e, 16'h26, 16'h6};
            5'd18: raw = {16'h546, 16'h2ee, 16'h5a, 16'h1e, 16'h5};
            5'd19: raw = {16'h654, 16'h384, 16'h50, 16'h19, 16'h5};
            5'd20: raw = {16'h80c, 16'h47e, 16'h46, 16'h14, 16'h4};
            5'd21: raw = {16'h9ce, 16'h578, 16'h3c, 16'h10, 16'h4};
            5'd22: raw = {16'hbea, 16'h6a4, 16'h32, 16'hd, 16'h3};
            5'd23: raw = {16'heba, 16'h834, 16'h28, 16'hb, 16'h3};
            5'd24: raw = {16'h118a, 16'h9c4, 16'h28, 16'h9, 16'h3};
            5'd25: raw = {16'h1388, 16'haf0, 16'h23, 16'h8, 16'h2};
            5'd26: raw = {16'h15e0, 16'hc1c, 16'h1e, 16'h7, 16'h2};
            5'd27: raw = {16'h17d4, 16'hd48, 16'h1e, 16'h7, 16'h2};
            5'd28: raw = {16'h19c8, 16'he74, 16'h19, 16'h6, 16'h2};
            5'd29: raw = {16'h1c20, 16'hfa0, 16'h19, 16'h6, 16'h2};
            5'd30: raw = {16'h1fa4, 16'h1194, 16'h14, 16'h5, 16'h2};
            5'd31: raw = {16'h2328, 16'h1388, 16'h14, 16'h5, 16'h2};
        endcase
    end

    always_comb begin
        row = raw;
        if (abs17 && raw.torq < `TF_MIN_ABS17) begin
            row.torq = `TF_MIN_ABS17;
        end
        if (large_frame) begin
            row.adj = raw.adj + `ADJ_FRAME_ADD;
        end
    end
endmodule

/* logic/save_timer.sv */
// periodic tick counter for the non-volatile save interval
`timescale 1ns/1ps
module save_timer #(
    parameter int W = 36,
    parameter logic [W-1:0] PERIOD = '1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic run,
    output logic tick
);
    logic [W-1:0] cnt_q;

    assign tick = run && (cnt_q == PERIOD - W'(1));

    // restarts from zero whenever tuning is switched off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else if (!run || tick) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
    end
endmodule

/* logic/servo_autotune_gain_scheduler.sv */
// auto-tuning parameter handling: overrides, stiffness gains, estimate save and restore
// Operation
// - tuning on forces observer and switching bits off
// - overrides affect behaviour, stored settings untouched
// - second inertia writable, switching stays disabled
// - disturbance settings writable, compensation stays disabled
// - save five estimates every thirty minutes
// - restore saved estimates at power-up
// - gains load only while motor stopped
// - mode zero freezes inertia estimate
// - stiffness table gives five values, both sets
// - 17-bit encoder clamps torque filter at 10
// - large frames add one to adjust filter
// - modes one to four update loop gains
// - modes one to three update adjust filter
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "servo_autotune_map.svh"
module servo_autotune_gain_scheduler
    import servo_autotune_pkg::*;
#(
    parameter logic [35:0] SAVE_CYCLES = 36'(`SAVE_CYCLES)
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // motor state
    input wire logic motor_stopped,
    // estimator
    input wire logic est_valid,
    input wire est_t est,
    // non-volatile memory
    output logic nvm_save_req,
    output est_t nvm_save_data,
    input wire logic nvm_save_ack,
    output logic nvm_load_req,
    input wire logic nvm_load_valid,
    input wire est_t nvm_load_data,
    // effective feature enables
    output logic speed_obs_en,
    output logic dist_obs_en,
    output logic inertia_sw_en,
    output logic dist_comp_en,
    // active gains
    output gains_t gains
);
    logic [15:0] regs_q [`REG_COUNT];
    logic wr_q;
    logic [4:0] widx_q;
    logic [31:0] rdata_q;

    logic pend_q;
    logic save_pend_q;
    est_t save_data_q;

    gains_t gains_q;
    boot_t boot_q;

    logic speed_obs_q;
    logic dist_obs_q;
    logic inertia_sw_q;
    logic dist_comp_q;

    logic addr_ok;
    logic [4:0] aidx;
    logic wr_hit;
    logic rd_hit;

    logic active;
    logic booted;
    logic load;
    logic tick;
    logic pend_set;
    logic est_take;

    logic tbl_gain;
    logic tbl_adj;
    row_t row;
    gains_t new_g;
    logic [15:0] effx;
    logic [15:0] status;
    logic [15:0] rd_word;

    // bus decode: one word per register, zero-wait, always OKAY
    assign aidx = haddr[6:2];
    assign addr_ok = (haddr[31:`REG_AW] == '0) && (haddr[1:0] == 2'b00)
                     && (aidx <= `IDX_STATUS);
    assign wr_hit = hsel && hready && htrans[1] && hwrite && addr_ok;
    assign rd_hit = hsel && hready && htrans[1] && !hwrite && addr_ok;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    // any nonzero mode means tuning on
    assign active = (regs_q[`IDX_MODE] != `REG_RESET);
    assign booted = (boot_q == boot_run);

    // any change that alters gains waits for the next stop
    assign pend_set = wr_q && (widx_q == `IDX_STIFF || widx_q == `IDX_MODE
                      || (widx_q >= `IDX_PG1 && widx_q <= `IDX_ADJ)
                      || widx_q == `IDX_CFG);
    assign load = pend_q && motor_stopped && booted;

    // estimation runs only while tuning is on
    assign est_take = est_valid && active && booted;

    // modes above four stay active, table untouched
    assign tbl_gain = active && regs_q[`IDX_MODE] <= `MODE_TABLE_MAX;
    assign tbl_adj = active && regs_q[`IDX_MODE] <= `MODE_ADJ_MAX;

    gain_table u_table (
        .level(regs_q[`IDX_STIFF]),
        .abs17(regs_q[`IDX_CFG][`CFG_ABS17]),
        .large_frame(regs_q[`IDX_CFG][`CFG_LARGE_FRAME]),
        .row(row)
    );

    // counts only while tuning runs after restore
    save_timer #(
        .W(36),
        .PERIOD(SAVE_CYCLES)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(active && booted),
        .tick(tick)
    );

    // gain set that a load would apply
    always_comb begin
        new_g.pg1 = regs_q[`IDX_PG1];
        new_g.vg1 = regs_q[`IDX_VG1];
        new_g.it1 = regs_q[`IDX_IT1];
        new_g.tf1 = regs_q[`IDX_TF1];
        new_g.pg2 = regs_q[`IDX_PG2];
        new_g.vg2 = regs_q[`IDX_VG2];
        new_g.it2 = regs_q[`IDX_IT2];
        new_g.tf2 = regs_q[`IDX_TF2];
        new_g.adj = regs_q[`IDX_ADJ];
        if (tbl_gain) begin
            new_g.pg1 = row.pos;
            new_g.vg1 = row.vel;
            new_g.it1 = row.integ;
            new_g.tf1 = row.torq;
            new_g.pg2 = row.pos;
            new_g.vg2 = row.vel;
            new_g.it2 = row.integ;
            new_g.tf2 = row.torq;
        end
        if (tbl_adj) begin
            new_g.adj = row.adj;
        end
    end

    // effective function bits; stored word left as written
    always_comb begin
        effx = regs_q[`IDX_FUNCX];
        if (active) begin
            effx[`FX_SPEED_OBS] = 1'b0;
            effx[`FX_DIST_OBS] = 1'b0;
            effx[`FX_INERTIA_SW] = 1'b0;
        end
    end

    always_comb begin
        status = '0;
        status[`ST_PENDING] = pend_q;
        status[`ST_ACTIVE] = active;
        status[`ST_BOOTED] = booted;
        status[`ST_SAVE_PEND] = save_pend_q;
        status[`ST_STOPPED] = motor_stopped;
    end

    always_comb begin
        if (aidx == `IDX_EFFX) begin
            rd_word = effx;
        end else if (aidx == `IDX_STATUS) begin
            rd_word = status;
        end else if (aidx > `IDX_CFG) begin
            // unmapped words read zero, never past the array
            rd_word = '0;
        end else begin
            rd_word = regs_q[aidx];
        end
    end

    // bus address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            widx_q <= '0;
        end else begin
            wr_q <= wr_hit && (aidx < `IDX_EFFX);
            widx_q <= aidx;
        end
    end

    // read data registered for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= '0;
        end else if (rd_hit) begin
            rdata_q <= {16'h0000, rd_word};
        end else begin
            rdata_q <= '0;
        end
    end

    // register file; software write lands last and wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                regs_q[i] <= `REG_RESET;
            end
        end else begin
            if (nvm_load_valid && !booted) begin
                regs_q[`IDX_INERTIA] <= nvm_load_data.inertia;
                regs_q[`IDX_TQOFS] <= nvm_load_data.tq_ofs;
                regs_q[`IDX_FRICP] <= nvm_load_data.fric_pos;
                regs_q[`IDX_FRICN] <= nvm_load_data.fric_neg;
                regs_q[`IDX_VISC] <= nvm_load_data.visc;
            end
            if (est_take) begin
                regs_q[`IDX_INERTIA] <= est.inertia;
                regs_q[`IDX_TQOFS] <= est.tq_ofs;
                regs_q[`IDX_FRICP] <= est.fric_pos;
                regs_q[`IDX_FRICN] <= est.fric_neg;
                regs_q[`IDX_VISC] <= est.visc;
            end
            if (load) begin
                regs_q[`IDX_PG1] <= new_g.pg1;
                regs_q[`IDX_VG1] <= new_g.vg1;
                regs_q[`IDX_IT1] <= new_g.it1;
                regs_q[`IDX_TF1] <= new_g.tf1;
                regs_q[`IDX_PG2] <= new_g.pg2;
                regs_q[`IDX_VG2] <= new_g.vg2;
                regs_q[`IDX_IT2] <= new_g.it2;
                regs_q[`IDX_TF2] <= new_g.tf2;
                regs_q[`IDX_ADJ] <= new_g.adj;
            end
            if (wr_q) begin
                // second inertia and disturbance settings always accept writes
                regs_q[widx_q] <= hwdata[15:0];
            end
        end
    end

    // change pending until the motor next stops; a new change wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_set || (pend_q && !load);
        end
    end

    // active gain set, updated at stops only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gains_q <= '0;
        end else if (load) begin
            gains_q <= new_g;
        end
    end
    assign gains = gains_q;

    // power-up restore of saved estimates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_q <= boot_load;
        end else begin
            unique case (boot_q)
                boot_load: begin
                    if (nvm_load_valid) begin
                        boot_q <= boot_run;
                    end
                end
                boot_run: begin
                    boot_q <= boot_run;
                end
            endcase
        end
    end
    assign nvm_load_req = (boot_q == boot_load);

    // periodic save; snapshot taken at the tick so data stays stable
    // a tick while a save is open takes no new snapshot and keeps the request up; the data must not move
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            save_pend_q <= 1'b0;
            save_data_q <= '0;
        end else begin
            save_pend_q <= tick || (save_pend_q && !nvm_save_ack);
            if (tick && !save_pend_q) begin
                save_data_q.inertia <= regs_q[`IDX_INERTIA];
                save_data_q.tq_ofs <= regs_q[`IDX_TQOFS];
                save_data_q.fric_pos <= regs_q[`IDX_FRICP];
                save_data_q.fric_neg <= regs_q[`IDX_FRICN];
                save_data_q.visc <= regs_q[`IDX_VISC];
            end
        end
    end
    assign nvm_save_req = save_pend_q;
    assign nvm_save_data = save_data_q;

    // observer enables follow the masked word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speed_obs_q <= 1'b0;
            dist_obs_q <= 1'b0;
        end else begin
            speed_obs_q <= effx[`FX_SPEED_OBS];
            dist_obs_q <= effx[`FX_DIST_OBS];
        end
    end

    // switching and compensation stay off while tuning
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inertia_sw_q <= 1'b0;
            dist_comp_q <= 1'b0;
        end else begin
            inertia_sw_q <= effx[`FX_INERTIA_SW];
            dist_comp_q <= effx[`FX_DIST_OBS];
        end
    end
    assign speed_obs_en = speed_obs_q;
    assign dist_obs_en = dist_obs_q;
    assign inertia_sw_en = inertia_sw_q;
    assign dist_comp_en = dist_comp_q;

endmodule

/* logic/servo_autotune_map.svh */
// offsets, field positions, reset values and timing counts of the auto-tuning block
`ifndef SERVO_AUTOTUNE_MAP_SVH
`define SERVO_AUTOTUNE_MAP_SVH

`define REG_DW 16
`define REG_AW 7
`define REG_COUNT 21
// word index of each register; byte address is four times the index
`define IDX_MODE 5'd0
`define IDX_STIFF 5'd1
`define IDX_INERTIA 5'd2
`define IDX_FUNCX 5'd3
`define IDX_INERTIA2 5'd4
`define IDX_DCGAIN 5'd5
`define IDX_DOFILT 5'd6
`define IDX_TQOFS 5'd7
`define IDX_FRICP 5'd8
`define IDX_FRICN 5'd9
`define IDX_VISC 5'd10
`define IDX_PG1 5'd11
`define IDX_VG1 5'd12
`define IDX_IT1 5'd13
`define IDX_TF1 5'd14
`define IDX_PG2 5'd15
`define IDX_VG2 5'd16
`define IDX_IT2 5'd17
`define IDX_TF2 5'd18
`define IDX_ADJ 5'd19
`define IDX_CFG 5'd20
`define IDX_EFFX 5'd21
`define IDX_STATUS 5'd22

// function expansion bits
`define FX_SPEED_OBS 0
`define FX_DIST_OBS 1
`define FX_INERTIA_SW 3
// configuration bits
`define CFG_ABS17 0
`define CFG_LARGE_FRAME 1
// status bits
`define ST_PENDING 0
`define ST_ACTIVE 1
`define ST_BOOTED 2
`define ST_SAVE_PEND 3
`define ST_STOPPED 4

`define REG_RESET 16'h0000
`define STIFF_MAX 16'h001f
`define MODE_TABLE_MAX 16'h0004
`define MODE_ADJ_MAX 16'h0003
`define TF_MIN_ABS17 16'h000a
`define ADJ_FRAME_ADD 16'h0001

`define CLK_HZ 25000000
`define SAVE_PERIOD_MIN 30
`define SAVE_CYCLES (64'(`SAVE_PERIOD_MIN) * 64'd60 * 64'(`CLK_HZ))

`endif

/* logic/servo_autotune_pkg.sv */
// types shared by the auto-tuning block
package servo_autotune_pkg;

    typedef struct packed {
        logic [15:0] inertia;
        logic [15:0] tq_ofs;
        logic [15:0] fric_pos;
        logic [15:0] fric_neg;
        logic [15:0] visc;
    } est_t;

    typedef struct packed {
        logic [15:0] pos;
        logic [15:0] vel;
        logic [15:0] integ;
        logic [15:0] torq;
        logic [15:0] adj;
    } row_t;

    typedef struct packed {
        logic [15:0] pg1;
        logic [15:0] vg1;
        logic [15:0] it1;
        logic [15:0] tf1;
        logic [15:0] pg2;
        logic [15:0] vg2;
        logic [15:0] it2;
        logic [15:0] tf2;
        logic [15:0] adj;
    } gains_t;

    typedef enum logic [0:0] {boot_load, boot_run} boot_t;

endpackage

/* testbench/motor_model.sv */
// motor, estimator and non-volatile memory on the far side
`timescale 1ns/1ps
module motor_model
    import servo_autotune_pkg::*;
#(
    parameter logic [79:0] NVM_INIT = 80'h0
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bench commands
    input wire logic run,
    input wire logic fire,
    input wire est_t est_in,
    input wire logic [3:0] ack_dly,
    // towards the block
    output logic motor_stopped,
    output logic est_valid,
    output est_t est,
    input wire logic nvm_save_req,
    input wire est_t nvm_save_data,
    output logic nvm_save_ack,
    input wire logic nvm_load_req,
    output logic nvm_load_valid,
    output est_t nvm_load_data
);
    est_t image;
    logic [1:0] spin;
    logic [3:0] wait_q;
    initial begin
        image = NVM_INIT;
        {motor_stopped, est_valid, nvm_save_ack, nvm_load_valid, spin, wait_q} = '0;
        est = '0;
        nvm_load_data = '0;
    end
    // memory image survives resets of the block
    always @(posedge hclk) begin
        spin <= run ? 2'h3 : spin - 2'(spin != 2'h0);
        motor_stopped <= (spin == 2'h0) && !run;
        est_valid <= fire;
        est <= fire ? est_in : ~est;
        nvm_load_valid <= hresetn && nvm_load_req && !nvm_load_valid;
        nvm_load_data <= (nvm_load_req && !nvm_load_valid) ? image : ~nvm_load_data;
        nvm_save_ack <= 1'b0;
        if (!nvm_save_req || nvm_save_ack) begin
            wait_q <= ack_dly;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end else begin
            nvm_save_ack <= 1'b1;
            image <= nvm_save_data;
        end
    end
endmodule

/* testbench/servo_autotune_gain_scheduler_sva.sv */
// port assertions for the auto-tuning gain scheduler
`timescale 1ns/1ps
module servo_autotune_gain_scheduler_sva
    import servo_autotune_pkg::*;
#(
    parameter logic [35:0] SAVE_CYCLES = 36'h64
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // motor and memory
    input wire logic motor_stopped,
    input wire logic nvm_save_req,
    input wire est_t nvm_save_data,
    input wire logic nvm_save_ack,
    input wire logic nvm_load_req,
    input wire logic nvm_load_valid,
    // effective outputs
    input wire logic dist_obs_en,
    input wire logic dist_comp_en,
    input wire gains_t gains
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_save_open;
        nvm_save_req && !nvm_save_ack;
    endsequence
    sequence s_save_kept;
        nvm_save_req && $stable(nvm_save_data);
    endsequence
    sequence s_load_open;
        nvm_load_req && !nvm_load_valid;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    a_save_held: assert property (s_save_open |=> s_save_kept)
        else $error("save request or data moved before ack");
    a_save_boot: assert property (nvm_load_req |-> !nvm_save_req)
        else $error("save requested before restore");
    a_load_held: assert property (s_load_open |=> nvm_load_req)
        else $error("restore request dropped early");
    a_load_done: assert property (nvm_load_req && nvm_load_valid |=> !nvm_load_req [*2])
        else $error("restore request kept after data");
    a_gain_stopped: assert property (!$stable(gains) |-> $past(motor_stopped))
        else $error("gains changed while moving");
    a_gain_boot: assert property (nvm_load_req |-> gains == '0)
        else $error("gains loaded before restore");
    a_comp_obs: assert property (dist_comp_en == dist_obs_en)
        else $error("compensation enable apart from observer");
endmodule
bind servo_autotune_gain_scheduler servo_autotune_gain_scheduler_sva #(
    .SAVE_CYCLES(SAVE_CYCLES)
) i_sva (
    .hclk(hclk),
    .hresetn(hresetn),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .motor_stopped(motor_stopped),
    .nvm_save_req(nvm_save_req),
    .nvm_save_data(nvm_save_data),
    .nvm_save_ack(nvm_save_ack),
    .nvm_load_req(nvm_load_req),
    .nvm_load_valid(nvm_load_valid),
    .dist_obs_en(dist_obs_en),
    .dist_comp_en(dist_comp_en),
    .gains(gains)
);

/* testbench/tb.sv */
// self-checking bench for the auto-tuning gain scheduler
`timescale 1ns/1ps
`include "servo_autotune_map.svh"
module tb
    import servo_autotune_pkg::*;
;
    typedef struct packed {logic [15:0] lvl, cfg, mode, pg, vg, it, tf, adj;} case_t;
    localparam logic [79:0] NVM_INIT = 80'h0123_4567_89ab_cdef_0f1e;
    logic hclk, hresetn, hsel, hwrite, run, fire, hreadyout, hresp, motor_stopped, est_valid;
    logic nvm_save_req, nvm_save_ack, nvm_load_req, nvm_load_valid, rd_ph;
    logic speed_obs_en, dist_obs_en, inertia_sw_en, dist_comp_en;
    logic [31:0] haddr, hwdata, hrdata;
    logic [31:0] exp_q[$];
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] ack_dly;
    logic [15:0] fx;
    est_t est, est_in, nvm_save_data, nvm_load_data, e1;
    gains_t gains, g_exp;
    int failures, checks_done, n;
    integer seed;
    case_t cases [4] = '{
        '{16'h0, 16'h0, 16'h1, 16'h14, 16'hf, 16'he74, 16'h5dc, 16'h9b},
        '{16'h28, 16'h2, 16'h2, 16'h2328, 16'h1388, 16'h14, 16'h5, 16'h3},
        '{16'h18, 16'h1, 16'h3, 16'h118a, 16'h9c4, 16'h28, 16'ha, 16'h3},
        '{16'hd, 16'h0, 16'h4, 16'h1e0, 16'h10e, 16'hd2, 16'h54, 16'h3}};
    servo_autotune_gain_scheduler #(.SAVE_CYCLES(36'h64)) i_servo_autotune_gain_scheduler (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .motor_stopped(motor_stopped),
        .est_valid(est_valid), .est(est), .nvm_save_req(nvm_save_req),
        .nvm_save_data(nvm_save_data), .nvm_save_ack(nvm_save_ack), .nvm_load_req(nvm_load_req),
        .nvm_load_valid(nvm_load_valid), .nvm_load_data(nvm_load_data),
        .speed_obs_en(speed_obs_en), .dist_obs_en(dist_obs_en), .inertia_sw_en(inertia_sw_en),
        .dist_comp_en(dist_comp_en), .gains(gains));
    motor_model #(.NVM_INIT(NVM_INIT)) i_motor_model (
        .hclk(hclk), .hresetn(hresetn), .run(run), .fire(fire), .est_in(est_in),
        .ack_dly(ack_dly), .motor_stopped(motor_stopped), .est_valid(est_valid), .est(est),
        .nvm_save_req(nvm_save_req), .nvm_save_data(nvm_save_data),
        .nvm_save_ack(nvm_save_ack), .nvm_load_req(nvm_load_req),
        .nvm_load_valid(nvm_load_valid), .nvm_load_data(nvm_load_data));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task automatic chk(input string name, input logic [143:0] e, input logic [143:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic timeout;
        failures++;
        wrap_up();
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask
    task automatic until_ready;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) timeout();
    endtask
    // address phase is held until ready, then data phase until ready again
    task automatic xfer(input logic wr, input logic [4:0] idx, input logic [15:0] wd);
        hsel <= 1'b1;
        haddr <= {25'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        until_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, wd};
        until_ready();
    endtask
    task automatic rd(input logic [4:0] idx, input logic [15:0] e);
        exp_q.push_back({16'h0, e});
        xfer(1'b0, idx, 16'h0);
    endtask
    task automatic est_rd(input est_t e);
        rd(`IDX_INERTIA, e.inertia);
        rd(`IDX_TQOFS, e.tq_ofs);
        rd(`IDX_FRICP, e.fric_pos);
        rd(`IDX_FRICN, e.fric_neg);
        rd(`IDX_VISC, e.visc);
    endtask
    task automatic boot_wait;
        n = 0;
        while (nvm_load_req !== 1'b0 && n < 20) begin @(posedge hclk); n++; end
        if (nvm_load_req !== 1'b0) timeout();
    endtask
    task automatic fire_est(input est_t e);
        est_in <= e;
        fire <= 1'b1;
        cyc(1);
        fire <= 1'b0;
        cyc(3);
    endtask
    // read data is compared in the data phase cycle only
    always @(posedge hclk) begin
        if (rd_ph) chk("hrdata", 144'(exp_q.pop_front()), 144'(hrdata));
        rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
    end
    initial begin
        seed = 32'hf430;
        {hresetn, hsel, hwrite, fire, rd_ph, htrans, haddr, hwdata} = '0;
        {failures, checks_done} = '0;
        run = 1'b1;
        hsize = 3'h2;
        ack_dly = 4'h5;
        est_in = '0;
        g_exp = '0;
        fx = 16'h000b | 16'($random(seed));
        cyc(4);
        hresetn <= 1'b1;
        boot_wait();
        est_rd(NVM_INIT);
        xfer(1'b1, `IDX_FUNCX, fx);
        cyc(2);
        chk("enables", 144'({speed_obs_en, inertia_sw_en, dist_comp_en}), 144'(3'h7));
        xfer(1'b1, `IDX_MODE, 16'h1);
        cyc(2);
        chk("enables", 144'({speed_obs_en, dist_obs_en, inertia_sw_en}), 144'(3'h0));
        rd(`IDX_EFFX, fx & ~16'h000b);
        rd(`IDX_FUNCX, fx);
        for (int i = 0; i < 3; i++) begin
            e1.visc = 16'($random(seed));
            xfer(1'b1, `IDX_INERTIA2 + 5'(i), e1.visc);
            rd(`IDX_INERTIA2 + 5'(i), e1.visc);
        end
        chk("enables", 144'({inertia_sw_en, dist_comp_en}), 144'(2'h0));
        foreach (cases[i]) begin
            xfer(1'b1, `IDX_CFG, cases[i].cfg);
            xfer(1'b1, `IDX_MODE, cases[i].mode);
            xfer(1'b1, `IDX_STIFF, cases[i].lvl);
            cyc(3);
            chk("gains moving", 144'(g_exp), 144'(gains));
            g_exp = '{cases[i].pg, cases[i].vg, cases[i].it, cases[i].tf, cases[i].pg,
                cases[i].vg, cases[i].it, cases[i].tf,
                (cases[i].mode == 16'h4) ? g_exp.adj : cases[i].adj};
            run <= 1'b0;
            n = 0;
            while (motor_stopped !== 1'b1 && n < 20) begin @(posedge hclk); n++; end
            if (motor_stopped !== 1'b1) timeout();
            cyc(1);
            chk("gains stopped", 144'(g_exp), 144'(gains));
            rd(`IDX_PG2, cases[i].pg);
            run <= 1'b1;
            cyc(2);
        end
        e1 = 80'({$random(seed), $random(seed), $random(seed)});
        fire_est(e1);
        est_rd(e1);
        xfer(1'b1, `IDX_MODE, 16'h0);
        fire_est(~e1);
        rd(`IDX_INERTIA, e1.inertia);
        chk("enables", 144'({speed_obs_en, dist_obs_en, inertia_sw_en}), 144'(3'h7));
        xfer(1'b1, `IDX_MODE, 16'h1);
        n = 0;
        while (nvm_save_req !== 1'b1 && n < 300) begin @(posedge hclk); n++; end
        if (nvm_save_req !== 1'b1) timeout();
        chk("save spacing", 144'(n >= 98 && n <= 103), 144'(1'b1));
        chk("saved estimates", 144'(e1), 144'(nvm_save_data));
        cyc(10);
        hresetn <= 1'b0;
        cyc(4);
        hresetn <= 1'b1;
        boot_wait();
        est_rd(e1);
        cyc(3);
        wrap_up();
    end
endmodule
